// *** hw/bfsce_exec.sv ***
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
module bfsce_exec #(
  parameter int unsigned PST_CYCLES  = bfsce_pkg::PST_CYC_DEF,
  parameter int unsigned STACK_DEPTH = bfsce_pkg::STACK_DEPTH_DEF,
  parameter int unsigned PM_DEPTH    = bfsce_pkg::PM_DEPTH_DEF
)(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire logic [bfsce_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic      [1:0]                   bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [bfsce_pkg::ADDR_W-1:0] araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic      [31:0]                  rdata,
  output logic      [1:0]                   rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  output logic                              busy,
  output logic                              sleep_req,
  output logic                              wdt_restart,
  output logic                              debug_break
);
  import bfsce_pkg::*;

  localparam int unsigned SP_W  = $clog2(STACK_DEPTH);
  localparam int unsigned PM_AW = $clog2(PM_DEPTH);
  localparam logic [SP_W-1:0] SP_RST = SP_W'(STACK_DEPTH - 1);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] addr_kind(input logic [11:0] a);
    logic [2:0] k;
    k = K_NONE;
    if (a == CMD_OFF)
      k = K_CMD;
    else if (a == STAT_OFF)
      k = K_STAT;
    else if (a == CTRL_OFF)
      k = K_CTRL;
    else if (a == SP_OFF)
      k = K_SP;
    else if (a[11:7] == RF_PFX && a[1:0] == 2'h0)
      k = K_RF;
    else if (a[11:8] == IO_PFX && a[1:0] == 2'h0)
      k = K_IO;
    return k;
  endfunction : addr_kind

  function automatic logic [31:0] strobe_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : strobe_merge

  // cycles spent in the execute state, minus one
  function automatic logic [7:0] exec_len(input logic [4:0] op);
    logic [7:0] n;
    case (op)
      OP_PLD:  n = 8'(PLD_CYC - 1);
      OP_PST:  n = 8'(PST_CYCLES - 1);
      OP_PUSH,
      OP_POP,
      OP_IOS,
      OP_IOC:  n = 8'(TWO_CYC - 1);
      default: n = 8'(ONE_CYC - 1);
    endcase
    return n;
  endfunction : exec_len

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]  rf_mem  [32];
  logic [7:0]  io_mem  [64];
  logic [7:0]  stk_mem [STACK_DEPTH];
  logic [15:0] pm_mem  [PM_DEPTH];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  bfsce_state_t st_r, st_nxt;
  logic [7:0]   cnt_r, cnt_nxt;
  logic [31:0]  cmd_r, cmd_nxt;
  logic [7:0]   stat_r, stat_nxt;
  logic [SP_W-1:0] sp_r, sp_nxt;
  logic         slp_r, slp_nxt;
  logic         wdt_r, wdt_nxt;
  logic         brk_r, brk_nxt;
  logic         aw_got_r, aw_got_nxt;
  logic         w_got_r, w_got_nxt;
  logic [11:0]  awaddr_r, awaddr_nxt;
  logic [31:0]  wdata_r, wdata_nxt;
  logic [3:0]   wstrb_r, wstrb_nxt;
  logic         bvalid_r, bvalid_nxt;
  logic [1:0]   bresp_r, bresp_nxt;
  logic         rvalid_r, rvalid_nxt;
  logic [31:0]  rdata_r, rdata_nxt;
  logic [1:0]   rresp_r, rresp_nxt;

  logic        aw_hs, w_hs, ar_hs, wr_go, wr_ok;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [2:0]  wkind, rkind;

  assign busy    = (st_r == ST_EXEC);
  assign awready = ce & ~aw_got_r & ~bvalid_r;
  assign wready  = ce & ~w_got_r & ~bvalid_r;
  assign arready = ce & ~rvalid_r;
  assign aw_hs   = awvalid & awready;
  assign w_hs    = wvalid & wready;
  assign ar_hs   = arvalid & arready;
  assign wa      = aw_got_r ? awaddr_r : awaddr;
  assign wd      = w_got_r ? wdata_r : wdata;
  assign ws      = w_got_r ? wstrb_r : wstrb;
  assign wkind   = addr_kind(wa);
  assign rkind   = addr_kind(araddr);
  assign wr_go   = ce & ~bvalid_r & (aw_got_r | aw_hs) & (w_got_r | w_hs);
  // a running command owns all operand state, so the bus may not touch it
  assign wr_ok   = (wkind == K_CTRL) || (wkind != K_NONE && !busy);

  assign bvalid      = bvalid_r;
  assign bresp       = bresp_r;
  assign rvalid      = rvalid_r;
  assign rresp       = rresp_r;
  assign rdata       = rdata_r;
  assign sleep_req   = slp_r;
  assign wdt_restart = wdt_r;
  assign debug_break = brk_r;

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (aw_hs)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (w_hs)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (bvalid_r && bready)
      bvalid_nxt = 1'b0;
    if (wr_go)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_r && rready)
      rvalid_nxt = 1'b0;
    if (ar_hs)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (rkind)
        K_CMD:   rdata_nxt = cmd_r;
        K_STAT:  rdata_nxt = {24'h00_0000, stat_r};
        K_CTRL:  rdata_nxt = {31'h0000_0000, busy};
        K_SP:    rdata_nxt = 32'(sp_r);
        K_RF:    rdata_nxt = {24'h00_0000, rf_mem[araddr[6:2]]};
        K_IO:    rdata_nxt = {24'h00_0000, io_mem[araddr[7:2]]};
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (ce)
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // execution
  // ----------------------------------------------------------------------
  logic [4:0]  op;
  logic [4:0]  rd;
  logic [2:0]  bsel;
  logic [5:0]  pa;
  logic [7:0]  rd_val, io_val, sh_res, bmask;
  logic [15:0] zp;
  logic        sh_z, sh_c, sh_n, sh_v, commit, bus_wr;

  assign op     = cmd_r[OPC_LSB +: 5];
  assign rd     = cmd_r[REG_LSB +: 5];
  assign bsel   = cmd_r[BIT_LSB +: 3];
  assign pa     = cmd_r[IO_LSB +: 6];
  assign rd_val = rf_mem[rd];
  assign io_val = io_mem[pa];
  assign zp     = {rf_mem[31], rf_mem[30]};
  assign bmask  = 8'h01 << bsel;
  assign commit = busy && (cnt_r == 8'h00);
  assign bus_wr = wr_go && wr_ok;

  bfsce_shift u_shift (
    .op     (op),
    .din    (rd_val),
    .cin    (stat_r[SB_C]),
    .dout   (sh_res),
    .flag_z (sh_z),
    .flag_c (sh_c),
    .flag_n (sh_n),
    .flag_v (sh_v)
  );

  logic            rf_we, z_we, io_we, stk_we, pm_we;
  logic [4:0]      rf_wa;
  logic [7:0]      rf_wd, io_wd;
  logic [5:0]      io_wa;
  logic [SP_W-1:0] stk_wa;
  logic [15:0]     pm_rd;

  assign pm_rd = pm_mem[zp[PM_AW:1]];

  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    cmd_nxt  = cmd_r;
    stat_nxt = stat_r;
    sp_nxt   = sp_r;
    slp_nxt  = 1'b0;
    wdt_nxt  = 1'b0;
    brk_nxt  = 1'b0;
    rf_we    = 1'b0;
    rf_wa    = rd;
    rf_wd    = sh_res;
    z_we     = 1'b0;
    io_we    = 1'b0;
    io_wa    = pa;
    io_wd    = rd_val;
    stk_we   = 1'b0;
    stk_wa   = sp_r;
    pm_we    = 1'b0;
    if (busy)
      cnt_nxt = cnt_r - 8'h01;
    if (bus_wr)
    begin
      case (wkind)
        K_CMD:
        begin
          cmd_nxt = strobe_merge(cmd_r, wd, ws);
          st_nxt  = ST_EXEC;
          cnt_nxt = exec_len(cmd_nxt[OPC_LSB +: 5]);
        end
        K_STAT: stat_nxt = 8'(strobe_merge(32'(stat_r), wd, ws));
        K_SP:   sp_nxt = SP_W'(strobe_merge(32'(sp_r), wd, ws));
        K_RF:
        begin
          rf_we = ws[0];
          rf_wa = wa[6:2];
          rf_wd = wd[7:0];
        end
        K_IO:
        begin
          io_we = ws[0];
          io_wa = wa[7:2];
          io_wd = wd[7:0];
        end
        default: st_nxt = st_r;
      endcase
    end
    if (commit)
    begin
      st_nxt = ST_IDLE;
      case (op)
        OP_PLD:
        begin
          rf_we = 1'b1;
          rf_wd = zp[0] ? pm_rd[15:8] : pm_rd[7:0];
          z_we  = 1'b1;
        end
        OP_PST:  pm_we = 1'b1;
        OP_IN:
        begin
          rf_we = 1'b1;
          rf_wd = io_val;
        end
        OP_OUT:  io_we = 1'b1;
        OP_PUSH:
        begin
          stk_we = 1'b1;
          sp_nxt = sp_r - 1'b1;
        end
        OP_POP:
        begin
          sp_nxt = sp_r + 1'b1;
          rf_we  = 1'b1;
          rf_wd  = stk_mem[sp_nxt];
        end
        OP_IOS:
        begin
          io_we = 1'b1;
          io_wd = io_val | bmask;
        end
        OP_IOC:
        begin
          io_we = 1'b1;
          io_wd = io_val & ~bmask;
        end
        OP_SHL,
        OP_SHR,
        OP_ROTL,
        OP_ROTR,
        OP_ASHR:
        begin
          rf_we        = 1'b1;
          stat_nxt[SB_Z] = sh_z;
          stat_nxt[SB_C] = sh_c;
          stat_nxt[SB_N] = sh_n;
          stat_nxt[SB_V] = sh_v;
        end
        OP_SWAP: rf_we = 1'b1;
        // one generic pair covers N, I, S and H flag instructions
        OP_FSET: stat_nxt[bsel] = 1'b1;
        OP_FCLR: stat_nxt[bsel] = 1'b0;
        OP_B2T:  stat_nxt[SB_T] = rd_val[bsel];
        OP_T2B:
        begin
          rf_we = 1'b1;
          rf_wd = stat_r[SB_T] ? (rd_val | bmask)
                               : (rd_val & ~bmask);
        end
        OP_SLEEP: slp_nxt = 1'b1;
        OP_WDT:   wdt_nxt = 1'b1;
        OP_BREAK: brk_nxt = 1'b1;
        default:  st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r   <= ST_IDLE;
      cnt_r  <= 8'h00;
      cmd_r  <= CMD_RST;
      stat_r <= STAT_RST;
      sp_r   <= SP_RST;
      slp_r  <= 1'b0;
      wdt_r  <= 1'b0;
      brk_r  <= 1'b0;
    end
    else if (ce)
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      cmd_r  <= cmd_nxt;
      stat_r <= stat_nxt;
      sp_r   <= sp_nxt;
      slp_r  <= slp_nxt;
      wdt_r  <= wdt_nxt;
      brk_r  <= brk_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // memory write ports
  // ----------------------------------------------------------------------
  // no reset on the arrays: software must load what it reads back
  always_ff @(posedge aclk)
  begin
    if (ce)
    begin
      if (z_we)
      begin
        rf_mem[30] <= 8'(zp + 16'h0001);
        rf_mem[31] <= 8'((zp + 16'h0001) >> 8);
      end
      if (rf_we)
        rf_mem[rf_wa] <= rf_wd;
      if (io_we)
        io_mem[io_wa] <= io_wd;
      if (stk_we)
        stk_mem[stk_wa] <= rd_val;
      if (pm_we)
        pm_mem[zp[PM_AW:1]] <= {rf_mem[1], rf_mem[0]};
    end
  end

endmodule : bfsce_exec

// *** hw/bfsce_shift.sv ***
`timescale 1ns/1ns
module bfsce_shift
  import bfsce_pkg::*;
(
  input  wire logic [bfsce_pkg::OPC_W-1:0] op,
  input  wire logic [7:0]                  din,
  input  wire logic                        cin,
  output logic      [7:0]                  dout,
  output logic                             flag_z,
  output logic                             flag_c,
  output logic                             flag_n,
  output logic                             flag_v
);

  // ----------------------------------------------------------------------
  // shifter and flag unit
  // ----------------------------------------------------------------------
  always_comb
  begin
    dout   = din;
    flag_c = cin;
    case (op)
      OP_SHL:
      begin
        dout   = {din[6:0], 1'b0};
        flag_c = din[7];
      end
      OP_SHR:
      begin
        dout   = {1'b0, din[7:1]};
        flag_c = din[0];
      end
      OP_ROTL:
      begin
        dout   = {din[6:0], cin};
        flag_c = din[7];
      end
      OP_ROTR:
      begin
        dout   = {cin, din[7:1]};
        flag_c = din[0];
      end
      OP_ASHR:
      begin
        dout   = {din[7], din[7:1]};
        flag_c = din[0];
      end
      OP_SWAP: dout = {din[3:0], din[7:4]};
      default: dout = din;
    endcase
    flag_z = (dout == 8'h00);
    flag_n = dout[7];
    // overflow after a shift is the sign change seen through carry
    flag_v = flag_n ^ flag_c;
  end

endmodule : bfsce_shift

// *** include/bfsce_pkg.sv ***
package bfsce_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 12;
  localparam logic [11:0] CMD_OFF  = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] CTRL_OFF = 12'h008;
  localparam logic [11:0] SP_OFF   = 12'h00C;
  localparam logic [4:0]  RF_PFX   = 5'h02;   // 0x100..0x17C, 32 words
  localparam logic [3:0]  IO_PFX   = 4'h2;    // 0x200..0x2FC, 64 words

  localparam logic [2:0] K_NONE = 3'h0;
  localparam logic [2:0] K_CMD  = 3'h1;
  localparam logic [2:0] K_STAT = 3'h2;
  localparam logic [2:0] K_CTRL = 3'h3;
  localparam logic [2:0] K_SP   = 3'h4;
  localparam logic [2:0] K_RF   = 3'h5;
  localparam logic [2:0] K_IO   = 3'h6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------------
  localparam int unsigned OPC_W   = 5;
  localparam int unsigned OPC_LSB = 0;
  localparam int unsigned REG_LSB = 8;
  localparam int unsigned BIT_LSB = 16;
  localparam int unsigned IO_LSB  = 24;

  localparam logic [4:0] OP_NOP   = 5'h00;
  localparam logic [4:0] OP_PLD   = 5'h01;
  localparam logic [4:0] OP_PST   = 5'h02;
  localparam logic [4:0] OP_IN    = 5'h03;
  localparam logic [4:0] OP_OUT   = 5'h04;
  localparam logic [4:0] OP_PUSH  = 5'h05;
  localparam logic [4:0] OP_POP   = 5'h06;
  localparam logic [4:0] OP_IOS   = 5'h07;
  localparam logic [4:0] OP_IOC   = 5'h08;
  localparam logic [4:0] OP_SHL   = 5'h09;
  localparam logic [4:0] OP_SHR   = 5'h0A;
  localparam logic [4:0] OP_ROTL  = 5'h0B;
  localparam logic [4:0] OP_ROTR  = 5'h0C;
  localparam logic [4:0] OP_ASHR  = 5'h0D;
  localparam logic [4:0] OP_SWAP  = 5'h0E;
  localparam logic [4:0] OP_FSET  = 5'h0F;
  localparam logic [4:0] OP_FCLR  = 5'h10;
  localparam logic [4:0] OP_B2T   = 5'h11;
  localparam logic [4:0] OP_T2B   = 5'h12;
  localparam logic [4:0] OP_SLEEP = 5'h13;
  localparam logic [4:0] OP_WDT   = 5'h14;
  localparam logic [4:0] OP_BREAK = 5'h15;

  // ----------------------------------------------------------------------
  // status register bits, reset values, cycle counts
  // ----------------------------------------------------------------------
  localparam int unsigned SB_C = 0;
  localparam int unsigned SB_Z = 1;
  localparam int unsigned SB_N = 2;
  localparam int unsigned SB_V = 3;
  localparam int unsigned SB_S = 4;
  localparam int unsigned SB_H = 5;
  localparam int unsigned SB_T = 6;
  localparam int unsigned SB_I = 7;

  localparam logic [7:0]  STAT_RST        = 8'h00;
  localparam logic [31:0] CMD_RST         = 32'h0000_0000;
  localparam int unsigned PLD_CYC         = 3;
  localparam int unsigned TWO_CYC         = 2;
  localparam int unsigned ONE_CYC         = 1;
  localparam int unsigned PST_CYC_DEF     = 4;
  localparam int unsigned STACK_DEPTH_DEF = 16;
  localparam int unsigned PM_DEPTH_DEF    = 256;

  typedef enum logic {ST_IDLE, ST_EXEC} bfsce_state_t;

endpackage : bfsce_pkg

// *** testbench/bfsce_exec_props.sv ***
`timescale 1ns/1ns
module bfsce_exec_props
  import bfsce_pkg::*;
#(
  parameter int unsigned PST_CYCLES = PST_CYC_DEF
)(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        busy,
  input wire logic        sleep_req,
  input wire logic        wdt_restart,
  input wire logic        debug_break
);
  // ------------------------------------------
  // checks
  // ------------------------------------------
  // the longest command bounds how long busy may stand
  localparam int BUSY_MAX = int'((PST_CYCLES > PLD_CYC) ? PST_CYCLES
                                                          : PLD_CYC);
  default clocking cb @(posedge aclk); endclocking
  // a low clock enable stretches every timing, so checks pause then
  default disable iff (!aresetn || !ce);

  a_sleep_at_end:
    assert property (sleep_req |-> $past(busy) && !busy)
    else $error("sleep pulse not at command end");
  a_wdt_at_end:
    assert property (wdt_restart |-> $past(busy) && !busy)
    else $error("watchdog pulse not at command end");
  a_break_at_end:
    assert property (debug_break |-> $past(busy) && !busy)
    else $error("break pulse not at command end");
  a_pulse_single:
    assert property (sleep_req || wdt_restart || debug_break
      |=> !(sleep_req || wdt_restart || debug_break))
    else $error("control pulse longer than one cycle");
  a_busy_bounded:
    assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("command ran longer than its length");
  a_write_answer:
    assert property ($rose(bvalid) |->
      $past(awvalid && awready || wvalid && wready))
    else $error("write response without a taken channel");
  a_read_answer:
    assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_resp_holds:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_data_holds:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_refused:
    assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
endmodule : bfsce_exec_props

bind bfsce_exec bfsce_exec_props #(.PST_CYCLES(PST_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
  .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .busy(busy), .sleep_req(sleep_req),
  .wdt_restart(wdt_restart), .debug_break(debug_break)
);

// *** testbench/bfsce_exec_tb.sv ***
`timescale 1ns/1ns
module bfsce_exec_tb;
  import bfsce_pkg::*;
  typedef struct packed {
    logic [4:0] op;
    logic [2:0] b;
    logic [7:0] ri;
    logic [7:0] si;
    logic [7:0] ro;
    logic [7:0] so;
    logic [2:0] pu;
  } bfsce_row_t;
  logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid;
  logic        rready, awready, wready, bvalid, arready, rvalid, busy;
  logic        sleep_req, wdt_restart, debug_break;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [2:0]  pul;
  int          bad_count, checks, cyc, ncyc;
  // shift rows keep S untouched; flag rows touch one bit only
  bfsce_row_t  rows [19] = '{
    {5'h09, 3'h0, 8'h81, 8'h00, 8'h02, 8'h09, 3'h0},
    {5'h09, 3'h0, 8'h00, 8'hFF, 8'h00, 8'hF2, 3'h0},
    {5'h0A, 3'h0, 8'h81, 8'h00, 8'h40, 8'h09, 3'h0},
    {5'h0B, 3'h0, 8'h80, 8'h11, 8'h01, 8'h19, 3'h0},
    {5'h0C, 3'h0, 8'h01, 8'h00, 8'h00, 8'h0B, 3'h0},
    {5'h0D, 3'h0, 8'h83, 8'h00, 8'hC1, 8'h05, 3'h0},
    {5'h0E, 3'h0, 8'hA5, 8'h3F, 8'h5A, 8'h3F, 3'h0},
    {5'h0F, 3'h2, 8'h33, 8'h00, 8'h33, 8'h04, 3'h0},
    {5'h10, 3'h2, 8'h33, 8'hFF, 8'h33, 8'hFB, 3'h0},
    {5'h0F, 3'h7, 8'h33, 8'h00, 8'h33, 8'h80, 3'h0},
    {5'h10, 3'h7, 8'h33, 8'hFF, 8'h33, 8'h7F, 3'h0},
    {5'h0F, 3'h4, 8'h33, 8'h00, 8'h33, 8'h10, 3'h0},
    {5'h0F, 3'h5, 8'h33, 8'h00, 8'h33, 8'h20, 3'h0},
    {5'h10, 3'h5, 8'h33, 8'hFF, 8'h33, 8'hDF, 3'h0},
    {5'h11, 3'h3, 8'hF7, 8'hFF, 8'hF7, 8'hBF, 3'h0},
    {5'h12, 3'h0, 8'hFF, 8'hBF, 8'hFE, 8'hBF, 3'h0},
    {5'h13, 3'h0, 8'h33, 8'hA5, 8'h33, 8'hA5, 3'h1},
    {5'h14, 3'h0, 8'h33, 8'hA5, 8'h33, 8'hA5, 3'h2},
    {5'h15, 3'h0, 8'h33, 8'hA5, 8'h33, 8'hA5, 3'h4}};

  bfsce_exec dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .busy(busy), .sleep_req(sleep_req),
    .wdt_restart(wdt_restart), .debug_break(debug_break));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // --------------------------------------------
  // bus tasks
  // --------------------------------------------
  function automatic logic [11:0] ad(input logic [11:0] b,
                                     input logic [5:0] n);
    return b | {4'h0, n, 2'h0};
  endfunction : ad

  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    ncyc = busy ? 1 : 0;
    bready <= 1'b0;
  endtask : wr

  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd_v = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk(nm, e, rd_v);
  endtask : rc

  // counts busy cycles and gathers the end-of-command pulses
  task automatic ex(input logic [4:0] op, r, input logic [2:0] b,
                    input logic [5:0] io, input int n);
    wr(12'h000, {2'h0, io, 5'h00, b, 3'h0, r, 3'h0, op});
    pul = 3'h0;
    forever
    begin
      @(posedge aclk);
      pul = pul | {debug_break, wdt_restart, sleep_req};
      if (!busy)
        break;
      ncyc++;
    end
    chk("cycles", n, ncyc);
  endtask : ex

  // --------------------------------------------
  // sequence
  // --------------------------------------------
  initial
  begin
    {ce, wstrb, aresetn, awvalid, wvalid, bready} = 9'h1F0;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc("status", 12'h004, 32'h0000_0000);
    rc("sp", 12'h00C, 32'h0000_000F);
    foreach (rows[i])
    begin
      wr(ad(12'h100, 6'h05), rows[i].ri);
      wr(12'h004, rows[i].si);
      ex(rows[i].op, 5'h05, rows[i].b, 6'h00, 1);
      chk("pulses", rows[i].pu, pul);
      rc("result", ad(12'h100, 6'h05), rows[i].ro);
      rc("flags", 12'h004, rows[i].so);
    end
    wr(ad(12'h100, 6'h00), 8'h3C);
    wr(ad(12'h100, 6'h01), 8'hC3);
    wr(ad(12'h100, 6'h1E), 8'h10);
    wr(ad(12'h100, 6'h1F), 8'h00);
    wr(12'h004, 8'h5A);
    // a register-file write landing mid-command must be refused
    wr(12'h000, 32'h0000_0002);
    wr(ad(12'h100, 6'h00), 8'hFF);
    chk("busy_resp", RESP_SLVERR, rs);
    ex(5'h02, 5'h00, 3'h0, 6'h00, PST_CYC_DEF);
    ex(5'h01, 5'h05, 3'h0, 6'h00, 3);
    rc("low_byte", ad(12'h100, 6'h05), 8'h3C);
    ex(5'h01, 5'h06, 3'h0, 6'h00, 3);
    rc("high_byte", ad(12'h100, 6'h06), 8'hC3);
    rc("pointer", ad(12'h100, 6'h1E), 8'h12);
    wr(ad(12'h100, 6'h07), 8'h96);
    ex(5'h05, 5'h07, 3'h0, 6'h00, 2);
    rc("sp", 12'h00C, 8'h0E);
    ex(5'h06, 5'h08, 3'h0, 6'h00, 2);
    rc("popped", ad(12'h100, 6'h08), 8'h96);
    rc("sp", 12'h00C, 8'h0F);
    wr(ad(12'h200, 6'h09), 8'hF0);
    ex(5'h07, 5'h00, 3'h0, 6'h09, 2);
    rc("io_set", ad(12'h200, 6'h09), 8'hF1);
    ex(5'h08, 5'h00, 3'h4, 6'h09, 2);
    rc("io_clear", ad(12'h200, 6'h09), 8'hE1);
    ex(5'h03, 5'h0A, 3'h0, 6'h09, 1);
    rc("port_in", ad(12'h100, 6'h0A), 8'hE1);
    ex(5'h04, 5'h07, 3'h0, 6'h0A, 1);
    rc("port_out", ad(12'h200, 6'h0A), 8'h96);
    rc("flags", 12'h004, 8'h5A);
    // a low clock enable stalls a running command and the bus
    wr(12'h000, 32'h0000_0002);
    chk("cmd_resp", RESP_OKAY, rs);
    ce <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("frozen", 32'h4, {busy, awready, arready});
    ce <= 1'b1;
    rc("ctrl_busy", 12'h008, 32'h0000_0001);
    chk("ctrl_resp", RESP_OKAY, rs);
    rc("ctrl_idle", 12'h008, 32'h0000_0000);
    rc("unmapped", 12'h010, 32'h0000_0000);
    chk("unmapped_resp", RESP_SLVERR, rs);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc("status", 12'h004, 32'h0000_0000);
    rc("sp", 12'h00C, 32'h0000_000F);
    summarize();
  end
endmodule : bfsce_exec_tb
